// *** verilog/slmc_regs.svh ***
// register indices, field positions, reset values and bus widths of the shared link controls
`ifndef SLMC_REGS_SVH
`define SLMC_REGS_SVH

`define SLMC_APB_AW            10
`define SLMC_APB_DW            32

`define SLMC_IDX_ENC_CTL       8'hBA
`define SLMC_IDX_RSV_BB        8'hBB
`define SLMC_IDX_FV_HOLD       8'hBC
`define SLMC_IDX_RSV_BD        8'hBD
`define SLMC_IDX_PD_DIS        8'hBE
`define SLMC_IDX_RSV_BF        8'hBF
`define SLMC_IDX_RSV_LO        8'hC0
`define SLMC_IDX_RSV_HI        8'hCF
`define SLMC_IDX_LINK_INFO     8'hF0
`define SLMC_IDX_STATUS        8'hF1

`define SLMC_ENC_CRC_DIS_BIT   7
`define SLMC_ST_FV_BIT         0
`define SLMC_ST_CRC_EN_BIT     1
`define SLMC_ST_DROP_BIT       2

`define SLMC_ENC_CRC_DIS_RST   1'b0
`define SLMC_ENC_CTL_LOW_VAL   7'h03
`define SLMC_RSV_BB_VAL        8'h74
`define SLMC_RSV_ZERO_VAL      8'h00
`define SLMC_FV_HOLD_RST       8'h80
`define SLMC_PD_DIS_RST        8'h00
`define SLMC_LINK_INFO_RST     8'h00

`endif

// *** verilog/slmc_pkg.sv ***
// types shared by the shared link controls block
`default_nettype none
package slmc_pkg;

  typedef enum logic [2:0] {
    SLMC_FV_IDLE  = 3'b001,
    SLMC_FV_COUNT = 3'b010,
    SLMC_FV_SENT  = 3'b100
  } slmc_fv_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } slmc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } slmc_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       crc_ok;
    logic [7:0] info;
  } slmc_pkt_t;

endpackage
`default_nettype wire

// *** verilog/slmc_fv_hold.sv ***
// frame-start generator: waits for frame-active to stay high for the programmed count
`timescale 1ns/1ps
`default_nettype none
module slmc_fv_hold #(
  parameter int CW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          fv_level,
  input  wire logic          raw_mode,
  input  wire logic [CW-1:0] hold_cycles,
  output var  logic          frame_start
);
  import slmc_pkg::*;

  typedef struct packed {
    slmc_fv_state_t st;
    logic [CW-1:0]  cnt;
    logic           pulse;
  } slmc_fvh_t;

  localparam slmc_fvh_t RST = '{st: SLMC_FV_IDLE, cnt: '0, pulse: 1'b0};

  slmc_fvh_t q;
  slmc_fvh_t d;

  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    unique case (q.st)
      SLMC_FV_IDLE: begin
        d.cnt = '0;
        if (raw_mode && fv_level) begin
          if (hold_cycles == '0) begin
            d.pulse = 1'b1;
            d.st    = SLMC_FV_SENT;
          end else begin
            d.cnt = CW'(1);
            d.st  = SLMC_FV_COUNT;
          end
        end
      end
      SLMC_FV_COUNT: begin
        if (!fv_level || !raw_mode) begin
          d.cnt = '0;
          d.st  = SLMC_FV_IDLE;
        end else if (q.cnt >= hold_cycles) begin
          d.pulse = 1'b1;
          d.st    = SLMC_FV_SENT;
        end else begin
          d.cnt = q.cnt + CW'(1);
        end
      end
      SLMC_FV_SENT: begin
        // one frame start per frame-active assertion
        if (!fv_level) begin
          d.cnt = '0;
          d.st  = SLMC_FV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign frame_start = q.pulse;

endmodule
`default_nettype wire

// *** verilog/slmc_top.sv ***
// shared link controls: encoder crc select, frame-active hold, pin pull-down disables, apb slave
//
// Overview of operation
// - bit 7 of link_encoder_control: 0 checks encoder crc, 1 skips it.
// - raw mode frame start waits until frame-active held the programmed count; resets 0x80.
// - a pin's pull-down is on while not in output mode, unless disabled.
// - disable bit 1 keeps pull-down off even for input-only pins; 0 leaves automatic.
// - one disable bit per pin, bit n for pin n, all reset to 0.
// - reserved range 0xC0 to 0xCF reads 0x00, has no function.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "slmc_regs.svh"
module slmc_top #(
  parameter int NPIN = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire slmc_pkg::slmc_apb_req_t apb_req,
  output var  slmc_pkg::slmc_apb_rsp_t apb_rsp,
  input  wire logic                  frame_active_input,
  input  wire logic                  raw_mode,
  input  wire slmc_pkg::slmc_pkt_t   link_pkt,
  input  wire logic [NPIN-1:0]       pin_output_mode,
  output var  logic [NPIN-1:0]       pulldown_en,
  output var  logic                  crc_check_en,
  output var  logic [7:0]            link_info,
  output var  logic                  frame_start
);
  import slmc_pkg::*;

  typedef struct packed {
    logic            fv_s1;
    logic            fv_s2;
    logic            fv_s3;
    logic            fv_level;
    logic            enc_crc_dis;
    logic [7:0]      fv_hold;
    logic [NPIN-1:0] pd_dis;
    logic [7:0]      info;
    logic            drop_seen;
    logic            crc_en;
    logic [NPIN-1:0] pd_en;
    slmc_apb_rsp_t   rsp;
  } slmc_state_t;

  localparam slmc_state_t RST = '{
    fv_s1:       1'b0,
    fv_s2:       1'b0,
    fv_s3:       1'b0,
    fv_level:    1'b0,
    enc_crc_dis: `SLMC_ENC_CRC_DIS_RST,
    fv_hold:     `SLMC_FV_HOLD_RST,
    pd_dis:      NPIN'(`SLMC_PD_DIS_RST),
    info:        `SLMC_LINK_INFO_RST,
    drop_seen:   1'b0,
    crc_en:      1'b1,
    pd_en:       '1,
    rsp:         '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000}
  };

  slmc_state_t q;
  slmc_state_t d;

  // register index of a byte address, valid only when word aligned and in range
  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic reg_mapped(input logic [9:0] addr);
    logic [7:0] idx;
    idx = reg_index(addr);
    reg_mapped = 1'b0;
    if (addr[1:0] == 2'b00) begin
      if ((idx >= `SLMC_IDX_ENC_CTL) && (idx <= `SLMC_IDX_RSV_HI)) begin
        reg_mapped = 1'b1;
      end
      if ((idx == `SLMC_IDX_LINK_INFO) || (idx == `SLMC_IDX_STATUS)) begin
        reg_mapped = 1'b1;
      end
    end
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] idx, input slmc_state_t s);
    reg_read = `SLMC_RSV_ZERO_VAL;
    if (idx == `SLMC_IDX_ENC_CTL) begin
      reg_read = {s.enc_crc_dis, `SLMC_ENC_CTL_LOW_VAL};
    end else if (idx == `SLMC_IDX_RSV_BB) begin
      reg_read = `SLMC_RSV_BB_VAL;
    end else if (idx == `SLMC_IDX_FV_HOLD) begin
      reg_read = s.fv_hold;
    end else if (idx == `SLMC_IDX_PD_DIS) begin
      reg_read = 8'(s.pd_dis);
    end else if (idx == `SLMC_IDX_LINK_INFO) begin
      reg_read = s.info;
    end else if (idx == `SLMC_IDX_STATUS) begin
      reg_read[`SLMC_ST_FV_BIT]     = s.fv_level;
      reg_read[`SLMC_ST_CRC_EN_BIT] = s.crc_en;
      reg_read[`SLMC_ST_DROP_BIT]   = s.drop_seen;
    end else begin
      reg_read = `SLMC_RSV_ZERO_VAL;
    end
  endfunction

  logic       acc_start;
  logic       acc_done;
  logic       wr_done;
  logic [7:0] acc_idx;
  logic [7:0] wbyte;

  assign acc_start = apb_req.psel && apb_req.penable && !q.rsp.pready;
  assign acc_done  = apb_req.psel && apb_req.penable && q.rsp.pready;
  assign wr_done   = acc_done && apb_req.pwrite && !q.rsp.pslverr && apb_req.pstrb[0];
  assign acc_idx   = reg_index(apb_req.paddr);
  assign wbyte     = apb_req.pwdata[7:0];

  always_comb begin
    d = q;

    // pin input: three stages, level changes once stages two and three agree
    d.fv_s1 = frame_active_input;
    d.fv_s2 = q.fv_s1;
    d.fv_s3 = q.fv_s2;
    if (q.fv_s2 == q.fv_s3) begin
      d.fv_level = q.fv_s3;
    end

    // apb: answer one cycle into the access phase, commit at the completing edge
    d.rsp.pready  = 1'b0;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata  = 32'h0000_0000;
    if (acc_start) begin
      d.rsp.pready  = 1'b1;
      d.rsp.pslverr = !reg_mapped(apb_req.paddr);
      if (!apb_req.pwrite && reg_mapped(apb_req.paddr)) begin
        d.rsp.prdata = {24'h00_0000, reg_read(acc_idx, q)};
      end
    end

    if (wr_done) begin
      if (acc_idx == `SLMC_IDX_ENC_CTL) begin
        d.enc_crc_dis = wbyte[`SLMC_ENC_CRC_DIS_BIT];
      end
      if (acc_idx == `SLMC_IDX_FV_HOLD) begin
        d.fv_hold = wbyte;
      end
      if (acc_idx == `SLMC_IDX_PD_DIS) begin
        d.pd_dis = wbyte[NPIN-1:0];
      end
      if ((acc_idx == `SLMC_IDX_STATUS) && wbyte[`SLMC_ST_DROP_BIT]) begin
        d.drop_seen = 1'b0;
      end
    end

    d.crc_en = !q.enc_crc_dis;

    // link information update; a set of the drop flag wins over its clear
    if (link_pkt.valid) begin
      // gate on the registered enable so the output and the stored value always agree
      if (link_pkt.crc_ok || !q.crc_en) begin
        d.info = link_pkt.info;
      end else begin
        d.drop_seen = 1'b1;
      end
    end

    d.pd_en = ~pin_output_mode & ~q.pd_dis;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  slmc_fv_hold #(
    .CW (8)
  ) u_fv_hold (
    .mclk        (mclk),
    .rstn        (rstn),
    .fv_level    (q.fv_level),
    .raw_mode    (raw_mode),
    .hold_cycles (q.fv_hold),
    .frame_start (frame_start)
  );

  assign apb_rsp      = q.rsp;
  assign pulldown_en  = q.pd_en;
  assign crc_check_en = q.crc_en;
  assign link_info    = q.info;

endmodule
`default_nettype wire

// *** verif/slmc_props.sv ***
// port assertions for the shared link controls
`timescale 1ns/1ps
`default_nettype none
module slmc_props #(
  parameter int NPIN = 8
) (
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire slmc_pkg::slmc_apb_req_t apb_req,
  input wire slmc_pkg::slmc_apb_rsp_t apb_rsp,
  input wire logic                    frame_active_input,
  input wire logic                    raw_mode,
  input wire slmc_pkg::slmc_pkt_t     link_pkt,
  input wire logic [NPIN-1:0]         pin_output_mode,
  input wire logic [NPIN-1:0]         pulldown_en,
  input wire logic                    crc_check_en,
  input wire logic [7:0]              link_info,
  input wire logic                    frame_start
);
  import slmc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic rsv = apb_req.paddr[9:6] == 4'hC && apb_req.paddr[1:0] == 2'b00;
  rsvd_zero_a: assert property (apb_rsp.pready && rsv && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("reserved read not zero");
  good_pkt_a: assert property (link_pkt.valid && (link_pkt.crc_ok || !crc_check_en)
    |=> link_info == $past(link_pkt.info)) else $error("packet not stored");
  bad_pkt_a: assert property (link_pkt.valid && !link_pkt.crc_ok && crc_check_en |=> $stable(link_info))
    else $error("bad crc packet stored");
  pd_out_a: assert property (rstn |=> (pulldown_en & $past(pin_output_mode)) == '0)
    else $error("pull-down on output pin");
  fs_once_a: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  fs_raw_a: assert property (frame_start |-> $past(raw_mode))
    else $error("frame start outside raw mode");
  // the filtered level trails the pin by three to four edges, the frame start by four to five
  fs_held_a: assert property (frame_start |->
    $past(frame_active_input, 4) || $past(frame_active_input, 5)) else $error("frame start without held input");
  ready_pulse_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable ##1 !apb_rsp.pready)
    else $error("ready outside access or held");
endmodule
bind slmc_top slmc_props #(.NPIN(NPIN)) u_props (.mclk(mclk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .frame_active_input(frame_active_input), .raw_mode(raw_mode), .link_pkt(link_pkt),
  .pin_output_mode(pin_output_mode), .pulldown_en(pulldown_en), .crc_check_en(crc_check_en),
  .link_info(link_info), .frame_start(frame_start));
`default_nettype wire

// *** verif/slmc_top_tb.sv ***
// self-checking bench for the shared link controls
`timescale 1ns/1ps
`default_nettype none
module slmc_top_tb;
  import slmc_pkg::*;
  logic          mclk = 1'b0;
  logic          rstn = 1'b0;
  slmc_apb_req_t req = '0;
  slmc_apb_rsp_t rsp;
  logic          fv = 1'b0;
  logic          raw = 1'b0;
  slmc_pkt_t     pkt = '0;
  logic [7:0]    omode = 8'h00;
  logic [7:0]    pd;
  logic          crc_en;
  logic [7:0]    info;
  logic          fs;
  logic [31:0]   rd;
  logic          err;
  int            n_errors = 0;
  int            tests_run = 0;
  int            cyc = 0;
  int            n_fs = 0;
  int            fs_at = 0;
  slmc_top DUT (.mclk(mclk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .frame_active_input(fv),
    .raw_mode(raw), .link_pkt(pkt), .pin_output_mode(omode), .pulldown_en(pd), .crc_check_en(crc_en),
    .link_info(info), .frame_start(fs));
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (fs === 1'b1) begin
      n_fs <= n_fs + 1;
      fs_at <= cyc;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d, 4'hF};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, 1'b0);
  endtask
  task automatic pkt_send(input logic ok, input logic [7:0] v);
    @(posedge mclk);
    pkt <= '{1'b1, ok, v};
    @(posedge mclk);
    pkt.valid <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_reset;
    rdchk(10'h2E8, 32'h03);
    rdchk(10'h2F0, 32'h80);
    rdchk(10'h2F8, 32'h00);
    rdchk(10'h2EC, 32'h74);
    chk(crc_en, 1'b1);
    chk(pd, 8'hFF);
    $display("test reset done");
  endtask
  task automatic t_rsvd;
    int i;
    for (i = 0; i < 16; i++) begin
      xfer(1'b1, 10'h300 + 10'(i * 4), 32'hFF);
      rdchk(10'h300 + 10'(i * 4), 32'h00);
    end
    xfer(1'b0, 10'h000, 32'h0);
    chk(err, 1'b1);
    $display("test reserved done");
  endtask
  task automatic t_pull;
    omode <= 8'h0F;
    xfer(1'b1, 10'h2F8, 32'hA5);
    rdchk(10'h2F8, 32'hA5);
    @(negedge mclk);
    chk(pd, 8'h50);
    @(posedge mclk);
    omode <= 8'hF0;
    xfer(1'b1, 10'h2F8, 32'h00);
    @(posedge mclk);
    @(negedge mclk);
    chk(pd, 8'h0F);
    $display("test pull-down done");
  endtask
  task automatic t_crc;
    pkt_send(1'b1, 8'h5C);
    chk(info, 8'h5C);
    pkt_send(1'b0, 8'hA3);
    chk(info, 8'h5C);
    rdchk(10'h3C4, 32'h06);
    xfer(1'b1, 10'h3C4, 32'h04);
    rdchk(10'h3C4, 32'h02);
    xfer(1'b1, 10'h2E8, 32'h80);
    rdchk(10'h2E8, 32'h83);
    chk(crc_en, 1'b0);
    pkt_send(1'b0, 8'hA3);
    chk(info, 8'hA3);
    // back to checking; the companion crc flag sits outside this block
    xfer(1'b1, 10'h2E8, 32'h00);
    $display("test crc done");
  endtask
  task automatic t_frame;
    int base;
    xfer(1'b1, 10'h2F0, 32'h04);
    raw <= 1'b1;
    fv <= 1'b1;
    repeat (3) @(posedge mclk);
    fv <= 1'b0;
    repeat (12) @(posedge mclk);
    chk(n_fs, 0);
    base = cyc;
    fv <= 1'b1;
    repeat (20) @(posedge mclk);
    fv <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(n_fs, 1);
    chk(fs_at - base >= 6 && fs_at - base <= 12, 1'b1);
    raw <= 1'b0;
    fv <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(n_fs, 1);
    $display("test frame done");
  endtask
  task automatic t_rerst;
    omode <= 8'h00;
    fv <= 1'b0;
    xfer(1'b1, 10'h2F0, 32'h11);
    xfer(1'b1, 10'h2F8, 32'hFF);
    pkt_send(1'b1, 8'h3C);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rdchk(10'h2F0, 32'h80);
    rdchk(10'h2F8, 32'h00);
    rdchk(10'h3C0, 32'h00);
    chk(pd, 8'hFF);
    $display("test mid-run reset done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_rsvd;
    t_pull;
    t_crc;
    t_frame;
    t_rerst;
    close_out;
  end
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
